// ---- verilog/potential_scan_sequencer.v ----
// potential programme sequencer: cyclic, linear sweep, step, hold and timed hold
// assumes go, trigger, stop and advance inputs are one-cycle pulses synchronous to core_clk
`timescale 1ns/1ps
`include "potential_scan_sequencer_regs.vh"
module potential_scan_sequencer #(
   parameter integer HMS_TICK_CYC = `HMS_RES_NS / `CLK_PERIOD_NS,
   parameter integer E_W          = 16
) (
   input  wire             core_clk,
   input  wire             nrst,
   input  wire             ce,
   input  wire [7:0]       addr,
   input  wire [31:0]      wdata,
   input  wire             wr,
   input  wire             rd,
   output reg  [31:0]      rdata,
   input  wire             go_key,
   input  wire             ext_trig,
   input  wire             stop_req,
   input  wire             adv_req,
   output reg  [E_W-1:0]   potential,
   output reg              cell_on,
   output reg              scan_active
);

   // ****************************************
   // constants and state codes
   // ****************************************
   localparam integer STEP_TICK_CYC = `STEP_RES_NS / `CLK_PERIOD_NS;
   localparam [7:0] S_IDLE  = 8'h01;
   localparam [7:0] S_ARMED = 8'h02;
   localparam [7:0] S_FWD   = 8'h04;
   localparam [7:0] S_RET   = 8'h08;
   localparam [7:0] S_WAIT  = 8'h10;
   localparam [7:0] S_STEP1 = 8'h20;
   localparam [7:0] S_STEP2 = 8'h40;
   localparam [7:0] S_HOLD  = 8'h80;

   // ****************************************
   // registers
   // ****************************************
   reg [6:0]     ctrl;
   reg           reject;
   reg [E_W-1:0] e_start;
   reg [E_W-1:0] e_vertex;
   reg [E_W-1:0] ramp_rate;
   reg [22:0]    t1_hms;
   reg [13:0]    t1_frac;
   reg [22:0]    t2_hms;
   reg [13:0]    t2_frac;
   reg [23:0]    step_t1;
   reg [23:0]    step_t2;
   reg [7:0]     state;
   reg [7:0]     next_state;
   reg           finish;
   reg [15:0]    presc;
   reg [6:0]     hh;
   reg [5:0]     hm;
   reg [5:0]     hs;
   reg [13:0]    hf;
   reg [23:0]    scnt;

   wire [2:0] mode     = ctrl[`CTRL_MODE_LSB+2:`CTRL_MODE_LSB];
   wire       end_open = ctrl[`CTRL_OPEN_BIT];
   wire       cont     = ctrl[`CTRL_CONT_BIT];
   wire       ext_mode = ctrl[`CTRL_EXT_BIT];
   wire       hold_md  = (mode == `MODE_HOLD) || (mode == `MODE_THOLD);

   wire cmd_wr     = wr && (addr == `CMD_OFS);
   wire rem_start  = cmd_wr && wdata[`CMD_START_BIT];
   wire stop_any   = stop_req || (cmd_wr && wdata[`CMD_STOP_BIT]);
   wire adv_any    = adv_req || (cmd_wr && wdata[`CMD_ADV_BIT]);
   wire trig_any   = go_key || rem_start;
   wire ctrl_bad   = wdata[`CTRL_CONT_BIT] || wdata[`CTRL_EXT_BIT] || !wdata[`CTRL_OPEN_BIT];
   wire [2:0] wmode = wdata[`CTRL_MODE_LSB+2:`CTRL_MODE_LSB];
   wire whold      = (wmode == `MODE_HOLD) || (wmode == `MODE_THOLD);

   wire hms_zero   = (hh == 7'h00) && (hm == 6'h00) && (hs == 6'h00) && (hf == 14'h0000);
   wire step_zero  = (scnt == 24'h000000);
   wire tick       = (presc == 16'h0000);
   wire moving     = (state != next_state);

   // ramp one rate step toward a target without overshooting it
   function [E_W-1:0] approach;
      input [E_W-1:0] cur;
      input [E_W-1:0] tgt;
      input [E_W-1:0] rate;
      begin
         if (cur < tgt) begin
            approach = (tgt - cur <= rate) ? tgt : cur + rate;
         end else begin
            approach = (cur - tgt <= rate) ? tgt : cur - rate;
         end
      end
   endfunction

   // ****************************************
   // sequencing
   // ****************************************
   always @* begin
      next_state = state;
      finish     = 1'b0;
      case (state)
         S_IDLE: begin
            if (trig_any) begin
               if (ext_mode && !hold_md) begin
                  next_state = S_ARMED; // R12
               end else if (hold_md) begin
                  next_state = S_HOLD; // R14
               end else if (mode == `MODE_STEP) begin
                  next_state = S_STEP1; // R12
               end else begin
                  next_state = S_FWD; // R12
               end
            end
         end
         S_ARMED: begin
            if (ext_trig) begin
               next_state = (mode == `MODE_STEP) ? S_STEP1 : S_FWD; // R12
            end
         end
         S_FWD: begin
            if (adv_any || potential == e_vertex) begin
               next_state = (mode == `MODE_CYC) ? S_RET : S_WAIT;
            end
         end
         S_RET: begin
            if (adv_any) begin
               finish = 1'b1;
            end else if (potential == e_start) begin
               if (cont) begin
                  next_state = S_FWD; // R05
               end else begin
                  finish = 1'b1; // R04
               end
            end
         end
         S_WAIT: begin
            if (adv_any || hms_zero) begin
               if (cont && !adv_any) begin
                  next_state = S_RET; // R07
               end else begin
                  finish = 1'b1; // R06
               end
            end
         end
         S_STEP1: begin
            if (adv_any || step_zero) begin
               next_state = S_STEP2;
            end
         end
         S_STEP2: begin
            if (adv_any || step_zero) begin
               if (cont && !adv_any) begin
                  next_state = S_STEP1; // R08
               end else begin
                  finish = 1'b1;
               end
            end
         end
         S_HOLD: begin
            if (adv_any || (mode == `MODE_THOLD && hms_zero)) begin
               finish = 1'b1; // R15 R16
            end
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
      if (finish) begin
         next_state = S_IDLE;
      end
   end

   // ****************************************
   // programme output and stage timers
   // ****************************************
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state       <= S_IDLE;
         potential   <= {E_W{1'b0}};
         cell_on     <= 1'b0;
         scan_active <= 1'b0;
         presc       <= 16'h0000;
         hh          <= 7'h00;
         hm          <= 6'h00;
         hs          <= 6'h00;
         hf          <= 14'h0000;
         scnt        <= 24'h000000;
      end else if (ce) begin
         // stop always releases control, never the programmed end condition
         if (stop_any) begin
            state       <= S_IDLE;
            cell_on     <= 1'b0;
            scan_active <= 1'b0;
         end else begin
            state       <= next_state;
            scan_active <= (next_state != S_IDLE);
            if (finish) begin
               if (end_open) begin
                  cell_on <= 1'b0; // R09 R11
               end else begin
                  potential <= e_start; // R10
               end
            end else if (state == S_IDLE && moving) begin
               cell_on   <= 1'b1;
               potential <= e_start;
            end else if (next_state == S_STEP2 && moving) begin
               potential <= e_vertex;
            end else if (next_state == S_STEP1 && moving) begin
               potential <= e_start; // R08
            end else if (tick && state == S_FWD && !moving) begin
               potential <= approach(potential, e_vertex, ramp_rate);
            end else if (tick && state == S_RET && !moving) begin
               potential <= approach(potential, e_start, ramp_rate); // R07
            end
         end
         // prescaler restarts at every stage entry so a stage gets whole ticks
         if (moving || tick) begin
            presc <= (next_state[5] || next_state[6]) ? STEP_TICK_CYC[15:0] - 16'h0001
                                                      : HMS_TICK_CYC[15:0] - 16'h0001; // R02 R03
         end else begin
            presc <= presc - 16'h0001;
         end
         if (moving && next_state == S_WAIT) begin
            {hh, hm, hs} <= {t2_hms[22:16], t2_hms[13:8], t2_hms[5:0]}; // R01
            hf           <= t2_frac;
         end else if (moving && next_state == S_HOLD) begin
            {hh, hm, hs} <= {t1_hms[22:16], t1_hms[13:8], t1_hms[5:0]}; // R01
            hf           <= t1_frac;
         end else if (tick && !hms_zero) begin
            // borrow chain across the sexagesimal fields
            if (hf != 14'h0000) begin
               hf <= hf - 14'h0001;
            end else begin
               hf <= `HMS_FRAC_MAX;
               if (hs != 6'h00) begin
                  hs <= hs - 6'h01;
               end else begin
                  hs <= `SEXA_MAX;
                  if (hm != 6'h00) begin
                     hm <= hm - 6'h01;
                  end else begin
                     hm <= `SEXA_MAX;
                     hh <= hh - 7'h01;
                  end
               end
            end
         end
         if (moving && next_state == S_STEP1) begin
            scnt <= step_t1; // R03
         end else if (moving && next_state == S_STEP2) begin
            scnt <= step_t2; // R03
         end else if (tick && !step_zero) begin
            scnt <= scnt - 24'h000001;
         end
      end
   end

   // ****************************************
   // register port
   // ****************************************
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl      <= `CTRL_RST;
         reject    <= 1'b0;
         e_start   <= {E_W{1'b0}};
         e_vertex  <= {E_W{1'b0}};
         ramp_rate <= {E_W{1'b0}};
         t1_hms    <= 23'h000000;
         t1_frac   <= 14'h0000;
         t2_hms    <= 23'h000000;
         t2_frac   <= 14'h0000;
         step_t1   <= 24'h000000;
         step_t2   <= 24'h000000;
         rdata     <= 32'h00000000;
      end else if (ce) begin
         if (wr) begin
            case (addr)
               `CTRL_OFS: begin
                  if (whold && ctrl_bad) begin
                     reject <= 1'b1; // R13
                  end else begin
                     reject <= 1'b0;
                     ctrl   <= wdata[6:0];
                  end
               end
               `E_START_OFS:   e_start   <= wdata[E_W-1:0];
               `E_VERTEX_OFS:  e_vertex  <= wdata[E_W-1:0];
               `RAMP_RATE_OFS: ramp_rate <= wdata[E_W-1:0];
               `T1_HMS_OFS:    t1_hms    <= wdata[22:0];
               `T1_FRAC_OFS:   t1_frac   <= wdata[13:0];
               `T2_HMS_OFS:    t2_hms    <= wdata[22:0];
               `T2_FRAC_OFS:   t2_frac   <= wdata[13:0];
               `STEP_T1_OFS:   step_t1   <= wdata[23:0];
               `STEP_T2_OFS:   step_t2   <= wdata[23:0];
               default: begin
               end
            endcase
         end
         if (rd) begin
            case (addr)
               `CTRL_OFS:      rdata <= {25'h0000000, ctrl};
               `STATUS_OFS:    rdata <= {21'h000000, reject, scan_active, cell_on, state};
               `E_START_OFS:   rdata <= {{(32-E_W){1'b0}}, e_start};
               `E_VERTEX_OFS:  rdata <= {{(32-E_W){1'b0}}, e_vertex};
               `RAMP_RATE_OFS: rdata <= {{(32-E_W){1'b0}}, ramp_rate};
               `T1_HMS_OFS:    rdata <= {9'h000, t1_hms};
               `T1_FRAC_OFS:   rdata <= {18'h00000, t1_frac};
               `T2_HMS_OFS:    rdata <= {9'h000, t2_hms};
               `T2_FRAC_OFS:   rdata <= {18'h00000, t2_frac};
               `STEP_T1_OFS:   rdata <= {8'h00, step_t1};
               `STEP_T2_OFS:   rdata <= {8'h00, step_t2};
               default:        rdata <= 32'h00000000;
            endcase
         end else begin
            rdata <= 32'h00000000;
         end
      end
   end

endmodule

// ---- shared/potential_scan_sequencer_regs.vh ----
// register offsets, field positions, reset values and timing for the scan sequencer
// assumes a 50 MHz core clock and a plain strobe register port with 8-bit byte addresses
//
// Functional notes
// R01: sweep and hold times are kept as hours, minutes, seconds and 1/10000 s, up to 99:59:59.9999.
// R02: those times count in 100 us steps.
// R03: step delays are 24-bit counts at 4 us each, at most 01:07.108860.
// R04: a single cyclic scan takes the end condition once the return ramp is back at the start.
// R05: a continuous cyclic scan turns straight round into the forward ramp, forever.
// R06: a single linear sweep takes the end condition when the end wait runs out.
// R07: a continuous linear sweep ramps back to start at the forward rate after the wait, forever.
// R08: a continuous step scan jumps back to start after the wait and repeats, forever.
// R09: open-circuit end in linear sweep or step mode releases the cell after the wait.
// R10: start-potential end in linear sweep or step mode drives the start potential at once.
// R11: open-circuit end in cyclic mode releases the cell as the return ramp completes.
// R12: manual trigger starts on the go key; external trigger waits for the rear trigger input.
// R13: hold modes accept only single, open-circuit and manual settings, others are rejected.
// R14: holds start on the go key or a remote start, never on the external trigger.
// R15: a timed hold releases the cell once the hold time has passed.
// R16: an indefinite hold keeps its potential until a stop or advance request.
`ifndef POTENTIAL_SCAN_SEQUENCER_REGS_VH
`define POTENTIAL_SCAN_SEQUENCER_REGS_VH

`define CTRL_OFS      8'h00
`define CMD_OFS       8'h04
`define STATUS_OFS    8'h08
`define E_START_OFS   8'h0c
`define E_VERTEX_OFS  8'h10
`define RAMP_RATE_OFS 8'h14
`define T1_HMS_OFS    8'h18
`define T1_FRAC_OFS   8'h1c
`define T2_HMS_OFS    8'h20
`define T2_FRAC_OFS   8'h24
`define STEP_T1_OFS   8'h28
`define STEP_T2_OFS   8'h2c

`define CTRL_MODE_LSB 0
`define CTRL_OPEN_BIT 4
`define CTRL_CONT_BIT 5
`define CTRL_EXT_BIT  6
`define CTRL_RST      7'h00

`define MODE_CYC      3'h0
`define MODE_LIN      3'h1
`define MODE_STEP     3'h2
`define MODE_HOLD     3'h3
`define MODE_THOLD    3'h4

`define CMD_START_BIT 0
`define CMD_STOP_BIT  1
`define CMD_ADV_BIT   2

`define HMS_HOUR_LSB  16
`define HMS_MIN_LSB   8
`define HMS_SEC_LSB   0
`define HMS_FRAC_MAX  14'h270f
`define SEXA_MAX      6'h3b

`define ST_CELL_BIT   8
`define ST_ACT_BIT    9
`define ST_REJ_BIT    10

`define CLK_PERIOD_NS 20
`define HMS_RES_NS    100000
`define STEP_RES_NS   4000

`endif

// ---- tb/trig_source.sv ----
// front-panel key, stop, advance and rear trigger source for the scan sequencer
// assumes the sequencer samples one-cycle pulses on the rising edge of core_clk
`timescale 1ns/1ps
module trig_source (
   input  wire logic core_clk,
   output logic      go_key,
   output logic      ext_trig,
   output logic      stop_req,
   output logic      adv_req
);
   initial begin
      {adv_req, stop_req, ext_trig, go_key} = 4'h0;
   end

   // m: [0] go key, [1] rear trigger, [2] stop, [3] advance
   // each press lasts exactly one cycle
   task hit(input logic [3:0] m);
      @(posedge core_clk);
      {adv_req, stop_req, ext_trig, go_key} <= m;
      @(posedge core_clk);
      {adv_req, stop_req, ext_trig, go_key} <= 4'h0;
   endtask
endmodule

// ---- tb/potential_scan_sequencer_asserts.sv ----
// port-level checker for the scan sequencer
// assumes single clock core_clk and async active-low nrst
`timescale 1ns/1ps
module scan_seq_checker #(
   parameter integer HMS_TICK_CYC = 5000,
   parameter integer E_W          = 16
) (
   input logic           core_clk,
   input logic           nrst,
   input logic           ce,
   input logic [7:0]     addr,
   input logic [31:0]    wdata,
   input logic           wr,
   input logic           rd,
   input logic [31:0]    rdata,
   input logic           go_key,
   input logic           ext_trig,
   input logic           stop_req,
   input logic           adv_req,
   input logic [E_W-1:0] potential,
   input logic           cell_on,
   input logic           scan_active
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   property p_rd_quiet;
      $past(ce) && !$past(rd) |-> rdata == 32'h0;
   endproperty
   a_rd_quiet: assert property (p_rd_quiet) else $error("rdata not zero");

   property p_stat_rd;
      ce && rd && addr == 8'h08 |=> rdata[31:11] == 21'h0
         && rdata[8] == $past(cell_on) && rdata[9] == $past(scan_active);
   endproperty
   a_stat_rd: assert property (p_stat_rd) else $error("status read wrong");

   property p_stop;
      ce && stop_req |=> !cell_on && !scan_active;
   endproperty
   a_stop: assert property (p_stop) else $error("stop did not release");

   property p_start_src;
      $rose(scan_active) |-> $past(ce && (go_key || wr));
   endproperty
   a_start_src: assert property (p_start_src) else $error("scan began unasked");

   property p_cell_src;
      $rose(cell_on) |-> $past(ce && (go_key || wr));
   endproperty
   a_cell_src: assert property (p_cell_src) else $error("cell engaged unasked");

   property p_ext_idle;
      ce && ext_trig && !scan_active && !go_key && !wr |=> !scan_active;
   endproperty
   a_ext_idle: assert property (p_ext_idle) else $error("trigger ran idle scan");

   property p_release;
      $fell(cell_on) |-> !scan_active;
   endproperty
   a_release: assert property (p_release) else $error("released mid scan");

   // a stalled clock enable must not let the programme drift
   property p_freeze;
      !ce |=> $stable(potential) && $stable(cell_on) && $stable(scan_active);
   endproperty
   a_freeze: assert property (p_freeze) else $error("moved while disabled");
endmodule

bind potential_scan_sequencer scan_seq_checker #(
   .HMS_TICK_CYC(HMS_TICK_CYC), .E_W(E_W)) i_chk (
   .core_clk(core_clk), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata),
   .wr(wr), .rd(rd), .rdata(rdata), .go_key(go_key), .ext_trig(ext_trig),
   .stop_req(stop_req), .adv_req(adv_req), .potential(potential),
   .cell_on(cell_on), .scan_active(scan_active));

// ---- tb/tb_top.sv ----
// self-checking bench for the scan sequencer
// assumes a short ramp tick of 10 cycles; step ticks stay 200 cycles
`timescale 1ns/1ps
module tb_top;
   logic        core_clk, nrst, ce, wr, rd;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, d;
   logic [15:0] potential;
   logic        go_key, ext_trig, stop_req, adv_req, cell_on, scan_active;
   int          n_mismatch, compares, n;

   potential_scan_sequencer #(.HMS_TICK_CYC(10), .E_W(16)) i_dut (
      .core_clk(core_clk), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .go_key(go_key), .ext_trig(ext_trig),
      .stop_req(stop_req), .adv_req(adv_req), .potential(potential),
      .cell_on(cell_on), .scan_active(scan_active));
   trig_source i_src (.core_clk(core_clk), .go_key(go_key), .ext_trig(ext_trig),
      .stop_req(stop_req), .adv_req(adv_req));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // ********************
   // shared tasks
   // ********************
   task chk(input string s, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      end
   endtask

   // one strobe cycle: w picks a write, else a read whose data lands in d
   task bus(input bit w, input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk);
      addr <= a;
      wdata <= v;
      wr <= w;
      rd <= !w;
      @(posedge core_clk);
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   task wreg(input logic [7:0] a, input logic [31:0] v);
      bus(1'b1, a, v);
   endtask

   task rreg(input logic [7:0] a);
      bus(1'b0, a, 32'h0);
   endtask

   // idl: wait for idle, else for the potential to reach v; n counts edges
   task wt(input bit idl, input logic [15:0] v, input int lim);
      n = 0;
      do begin
         @(posedge core_clk);
         #1;
         n++;
      end while ((idl ? scan_active !== 1'b0 : potential !== v) && n < lim);
      if (n >= lim) begin
         n_mismatch++;
         stop_test();
      end
   endtask

   // tick phase restarts at every stage entry, yet stage lengths are still given a window
   task rng(input int lo, input int hi);
      chk("stage cycles", 32'h1, 32'(n >= lo && n <= hi));
   endtask

   task go;
      i_src.hit(4'h1);
      #1;
   endtask

   task halt;
      i_src.hit(4'h4);
      #1;
      chk("cell", 32'h0, 32'(cell_on));
      chk("active", 32'h0, 32'(scan_active));
   endtask

   // ********************
   // scenarios
   // ********************
   task t_reset;
      rreg(8'h00);
      chk("ctrl", 32'h0, d);
      rreg(8'h08);
      chk("status", 32'h001, d);
      rreg(8'h3c);
      chk("unmapped", 32'h0, d);
      chk("pot", 32'h0, 32'(potential));
      $display("test reset done");
   endtask

   task t_times;
      wreg(8'h18, 32'h633b3b);
      wreg(8'h1c, 32'h270f);
      rreg(8'h18);
      chk("t1 hms", 32'h633b3b, d);
      rreg(8'h1c);
      chk("t1 frac", 32'h270f, d);
      $display("test times done");
   endtask

   task t_step;
      wreg(8'h28, 32'h2);
      wreg(8'h2c, 32'h1);
      wreg(8'h00, 32'h2);
      go();
      chk("pot", 32'h10, 32'(potential));
      wt(0, 16'h14, 500);
      rng(390, 410);
      wt(1, 16'h0, 300);
      rng(190, 210);
      chk("pot", 32'h10, 32'(potential));
      chk("cell", 32'h1, 32'(cell_on));
      wreg(8'h00, 32'h12);
      go();
      wt(1, 16'h0, 700);
      chk("cell", 32'h0, 32'(cell_on));
      wreg(8'h00, 32'h22);
      go();
      wt(0, 16'h14, 500);
      wt(0, 16'h10, 300);
      rng(190, 210);
      wt(0, 16'h14, 500);
      chk("active", 32'h1, 32'(scan_active));
      halt();
      $display("test step done");
   endtask

   task t_cyc;
      wreg(8'h00, 32'h0);
      go();
      wt(0, 16'h14, 50);
      rng(8, 22);
      wt(1, 16'h0, 50);
      chk("pot", 32'h10, 32'(potential));
      chk("cell", 32'h1, 32'(cell_on));
      wreg(8'h00, 32'h10);
      go();
      wt(1, 16'h0, 100);
      chk("cell", 32'h0, 32'(cell_on));
      wreg(8'h00, 32'h20);
      go();
      wt(0, 16'h14, 50);
      wt(0, 16'h10, 50);
      @(posedge core_clk);
      ce <= 1'b0;
      repeat (5) @(posedge core_clk);
      ce <= 1'b1;
      wt(0, 16'h14, 50);
      chk("active", 32'h1, 32'(scan_active));
      halt();
      $display("test cyclic done");
   endtask

   task t_lin;
      wreg(8'h20, 32'h0);
      wreg(8'h24, 32'h3);
      wreg(8'h00, 32'h1);
      go();
      wt(0, 16'h14, 50);
      wt(1, 16'h0, 80);
      rng(25, 36);
      chk("pot", 32'h10, 32'(potential));
      wreg(8'h00, 32'h21);
      go();
      wt(0, 16'h14, 50);
      wt(0, 16'h10, 100);
      wt(0, 16'h14, 50);
      chk("active", 32'h1, 32'(scan_active));
      halt();
      $display("test linear done");
   endtask

   task t_ext;
      wreg(8'h00, 32'h40);
      i_src.hit(4'h2);
      #1;
      chk("active", 32'h0, 32'(scan_active));
      go();
      chk("cell", 32'h1, 32'(cell_on));
      repeat (30) @(posedge core_clk);
      #1;
      chk("pot", 32'h10, 32'(potential));
      i_src.hit(4'h2);
      wt(0, 16'h14, 50);
      halt();
      $display("test trigger done");
   endtask

   task t_hold;
      logic [31:0] bad [3] = '{32'h33, 32'h53, 32'h03};
      foreach (bad[i]) begin
         wreg(8'h00, bad[i]);
         rreg(8'h08);
         chk("reject", 32'h1, 32'(d[10]));
      end
      rreg(8'h00);
      chk("ctrl", 32'h40, d);
      wreg(8'h00, 32'h13);
      rreg(8'h08);
      chk("reject", 32'h0, 32'(d[10]));
      i_src.hit(4'h2);
      #1;
      chk("active", 32'h0, 32'(scan_active));
      wreg(8'h04, 32'h1);
      chk("cell", 32'h1, 32'(cell_on));
      chk("pot", 32'h10, 32'(potential));
      repeat (100) @(posedge core_clk);
      #1;
      chk("cell", 32'h1, 32'(cell_on));
      i_src.hit(4'h8);
      #1;
      chk("cell", 32'h0, 32'(cell_on));
      wreg(8'h18, 32'h0);
      wreg(8'h1c, 32'h2);
      wreg(8'h00, 32'h14);
      go();
      wt(1, 16'h0, 40);
      rng(15, 26);
      chk("cell", 32'h0, 32'(cell_on));
      $display("test hold done");
   endtask

   // remote advance and stop through the command register
   task t_cmd;
      wreg(8'h00, 32'h0);
      go();
      wt(0, 16'h12, 20);
      wreg(8'h04, 32'h4);
      rreg(8'h08);
      chk("status", 32'h308, d);
      wt(1, 16'h0, 40);
      chk("pot", 32'h10, 32'(potential));
      chk("cell", 32'h1, 32'(cell_on));
      go();
      wreg(8'h04, 32'h2);
      chk("cell", 32'h0, 32'(cell_on));
      chk("active", 32'h0, 32'(scan_active));
      $display("test command done");
   endtask

   // reset in the middle of a running scan
   task t_rst;
      wreg(8'h00, 32'h20);
      go();
      @(posedge core_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      #1;
      chk("cell", 32'h0, 32'(cell_on));
      chk("active", 32'h0, 32'(scan_active));
      chk("pot", 32'h0, 32'(potential));
      rreg(8'h00);
      chk("ctrl", 32'h0, d);
      rreg(8'h08);
      chk("status", 32'h001, d);
      $display("test mid reset done");
   endtask

   task stop_test;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      nrst = 1'b0;
      ce = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h0;
      wdata = 32'h0;
      n_mismatch = 0;
      compares = 0;
      repeat (10) @(posedge core_clk);
      nrst <= 1'b1;
      t_reset();
      wreg(8'h0c, 32'h10);
      wreg(8'h10, 32'h14);
      wreg(8'h14, 32'h2);
      t_times();
      t_step();
      t_cyc();
      t_lin();
      t_ext();
      t_hold();
      t_cmd();
      t_rst();
      stop_test();
   end
endmodule
